// file: hdl/io_bus_pkg.sv
package io_bus_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 4;

  // all timing counts are in periods of the double-rate clock (SYS_CLK)
  localparam logic [CNT_W-1:0] ADDR_SETUP_CYC = 4'h5;
  localparam logic [CNT_W-1:0] RD_CMD_CYC     = 4'h9;
  localparam logic [CNT_W-1:0] WR_CMD_CYC     = 4'hA;
  localparam logic [CNT_W-1:0] RD_HOLD_CYC    = 4'h6;
  localparam logic [CNT_W-1:0] WR_HOLD_CYC    = 4'h7;
  localparam logic [CNT_W-1:0] RECOVERY_CYC   = 4'hB;
  localparam logic [CNT_W-1:0] MEM_ZW_WAITS   = 4'h0;
  localparam logic [CNT_W-1:0] MEM_OW_WAITS   = 4'h1;
  localparam logic [CNT_W-1:0] ACK_GAP_CYC    = 4'h4;
  localparam logic [CNT_W-1:0] CNT_ONE        = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO       = 4'h0;

  // address map
  localparam int               IO_SEL_LSB     = 4;
  localparam logic [1:0]       IO_SEL_IRQ     = 2'h0;
  localparam logic [1:0]       IO_SEL_SERIAL  = 2'h1;
  localparam int               MEM_SEL_LSB    = 14;
  localparam logic [1:0]       MEM_SEL_ZW     = 2'h0;
  localparam int               PADDR_LSB      = 2;
  localparam logic [ADDR_W-1:0] ACK1_ADDR     = 16'h0004;
  localparam logic [ADDR_W-1:0] ACK2_ADDR     = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET    = 16'h0000;

  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_SETUP = 3'h1,
    D_CMD   = 3'h3,
    D_HOLD  = 3'h2,
    D_MEM   = 3'h4
  } ctrl_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_ADS  = 2'h1,
    H_WAIT = 2'h3,
    H_GAP  = 2'h2
  } host_state_t;
endpackage

// file: hdl/local_bus_if.sv
`timescale 1ns/10ps
interface local_bus_if;
  import io_bus_pkg::*;
  logic              ads;
  logic [ADDR_W-1:0] addr;
  logic              w_r;
  logic              m_io;
  logic              d_c;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              ready;
  logic              next_addr_req;

  modport cpu  (output ads, addr, w_r, m_io, d_c, wdata, input rdata, ready, next_addr_req);
  modport ctrl (input ads, addr, w_r, m_io, d_c, wdata, output rdata, ready, next_addr_req);
endinterface

// file: hdl/io_sel_decode.sv
`timescale 1ns/10ps
module io_sel_decode (
  // processor address and space
  input  wire logic [io_bus_pkg::ADDR_W-1:0] addr,
  input  wire logic                          m_io,
  // selects
  output logic                               sel_zero_wait,
  output logic                               sel_one_wait,
  output logic                               irq_ctrl_select,
  output logic                               serial_ctrl_select
);
  import io_bus_pkg::*;

  // no latch stage, so selects reach the wait logic in the address cycle
  always_comb begin
    sel_zero_wait      = m_io && (addr[MEM_SEL_LSB +: 2] == MEM_SEL_ZW);
    sel_one_wait       = m_io && (addr[MEM_SEL_LSB +: 2] != MEM_SEL_ZW);
    irq_ctrl_select    = !m_io && (addr[IO_SEL_LSB +: 2] == IO_SEL_IRQ);
    serial_ctrl_select = !m_io && (addr[IO_SEL_LSB +: 2] == IO_SEL_SERIAL);
  end
endmodule

// file: hdl/io_cmd_ctrl.sv
`timescale 1ns/10ps
module io_cmd_ctrl (
  // clock and reset
  input  wire logic                          SYS_CLK,
  input  wire logic                          RST,
  // processor local bus
  local_bus_if.ctrl                          bus,
  // peripheral commands
  output logic                               IO_RD_CMD,
  output logic                               IO_WR_CMD,
  output logic                               MEM_RD_CMD,
  output logic                               IRQ_ACK_STROBE,
  // transceiver and selects
  output logic                               XCVR_ENABLE,
  output logic                               XCVR_DIR,
  output logic                               IRQ_CTRL_SELECT,
  output logic                               SERIAL_CTRL_SELECT,
  output logic [1:0]                         PERIPH_ADDR,
  // peripheral data, low byte lane
  input  wire logic [io_bus_pkg::DATA_W-1:0] PDATA_IN,
  output logic [io_bus_pkg::DATA_W-1:0]      PDATA_OUT,
  output logic                               PDATA_OE_N
);
  import io_bus_pkg::*;

  ctrl_state_t       state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [CNT_W-1:0]  rec_reg, rec_next;
  logic              is_wr_reg, is_wr_next;
  logic              is_ack_reg, is_ack_next;
  logic              rd_reg, rd_next;
  logic              wr_reg, wr_next;
  logic              mrd_reg, mrd_next;
  logic              ack_reg, ack_next;
  logic              xen_reg, xen_next;
  logic              xdir_reg, xdir_next;
  logic              irqs_reg, irqs_next;
  logic              sers_reg, sers_next;
  logic [1:0]        paddr_reg, paddr_next;
  logic [DATA_W-1:0] pout_reg, pout_next;
  logic              oe_n_reg, oe_n_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              ready_reg, ready_next;
  logic              na_reg, na_next;
  logic              sel_zero_wait;
  logic              sel_one_wait;
  logic              irq_ctrl_select;
  logic              serial_ctrl_select;

  io_sel_decode u_dec (
    .addr               (bus.addr),
    .m_io               (bus.m_io),
    .sel_zero_wait      (sel_zero_wait),
    .sel_one_wait       (sel_one_wait),
    .irq_ctrl_select    (irq_ctrl_select),
    .serial_ctrl_select (serial_ctrl_select)
  );

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    // down count that stops at zero; every I/O command reloads it
    rec_next    = (rec_reg != CNT_ZERO) ? rec_reg - CNT_ONE : rec_reg;
    is_wr_next  = is_wr_reg;
    is_ack_next = is_ack_reg;
    rd_next     = rd_reg;
    wr_next     = wr_reg;
    mrd_next    = mrd_reg;
    ack_next    = ack_reg;
    xen_next    = xen_reg;
    xdir_next   = xdir_reg;
    irqs_next   = irqs_reg;
    sers_next   = sers_reg;
    paddr_next  = paddr_reg;
    pout_next   = pout_reg;
    oe_n_next   = oe_n_reg;
    rdata_next  = rdata_reg;
    ready_next  = 1'b0;
    na_next     = na_reg;
    case (state_reg)
      D_IDLE: begin
        if (bus.ads) begin
          if (bus.m_io || (!bus.d_c && bus.w_r)) begin
            // memory cycle, or halt which just completes
            state_next = D_MEM;
            mrd_next   = bus.m_io && !bus.w_r;
            na_next    = sel_zero_wait;
            cnt_next   = sel_zero_wait ? MEM_ZW_WAITS : MEM_OW_WAITS;
          end else begin
            state_next  = D_SETUP;
            is_wr_next  = bus.w_r;
            is_ack_next = !bus.d_c;
            xdir_next   = bus.w_r;
            irqs_next   = irq_ctrl_select;
            sers_next   = serial_ctrl_select;
            paddr_next  = bus.addr[PADDR_LSB +: 2];
            pout_next   = bus.wdata;
            cnt_next    = ADDR_SETUP_CYC - CNT_ONE;
          end
        end
      end
      D_SETUP: begin
        if (cnt_reg != CNT_ZERO) begin
          cnt_next = cnt_reg - CNT_ONE;
        end else if (rec_reg == CNT_ZERO) begin
          state_next = D_CMD;
          rd_next    = !is_wr_reg && !is_ack_reg;
          wr_next    = is_wr_reg;
          ack_next   = is_ack_reg;
          xen_next   = 1'b1;
          oe_n_next  = !is_wr_reg;
          cnt_next   = is_wr_reg ? WR_CMD_CYC - CNT_ONE : RD_CMD_CYC - CNT_ONE;
        end
      end
      D_CMD: begin
        if (cnt_reg != CNT_ZERO) begin
          cnt_next = cnt_reg - CNT_ONE;
        end else begin
          state_next = D_HOLD;
          rd_next    = 1'b0;
          wr_next    = 1'b0;
          ack_next   = 1'b0;
          rec_next   = RECOVERY_CYC;
          // read data taken at the very end of the strobe, lowest lane only
          if (!is_wr_reg) begin
            rdata_next = PDATA_IN;
          end
          // write data stays on the bus through the hold for data hold time
          xen_next   = is_wr_reg;
          cnt_next   = is_wr_reg ? WR_HOLD_CYC - CNT_ONE : RD_HOLD_CYC - CNT_ONE;
        end
      end
      D_HOLD: begin
        if (cnt_reg != CNT_ZERO) begin
          cnt_next = cnt_reg - CNT_ONE;
        end else begin
          state_next = D_IDLE;
          ready_next = 1'b1;
          xen_next   = 1'b0;
          oe_n_next  = 1'b1;
          irqs_next  = 1'b0;
          sers_next  = 1'b0;
        end
      end
      D_MEM: begin
        if (cnt_reg != CNT_ZERO) begin
          cnt_next = cnt_reg - CNT_ONE;
        end else begin
          state_next = D_IDLE;
          ready_next = 1'b1;
          mrd_next   = 1'b0;
          na_next    = 1'b0;
        end
      end
      default: begin
        state_next = D_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_reg  <= D_IDLE;
      cnt_reg    <= CNT_ZERO;
      rec_reg    <= CNT_ZERO;
      is_wr_reg  <= 1'b0;
      is_ack_reg <= 1'b0;
      rd_reg     <= 1'b0;
      wr_reg     <= 1'b0;
      mrd_reg    <= 1'b0;
      ack_reg    <= 1'b0;
      xen_reg    <= 1'b0;
      xdir_reg   <= 1'b0;
      irqs_reg   <= 1'b0;
      sers_reg   <= 1'b0;
      paddr_reg  <= 2'h0;
      pout_reg   <= DATA_RESET;
      oe_n_reg   <= 1'b1;
      rdata_reg  <= DATA_RESET;
      ready_reg  <= 1'b0;
      na_reg     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      rec_reg    <= rec_next;
      is_wr_reg  <= is_wr_next;
      is_ack_reg <= is_ack_next;
      rd_reg     <= rd_next;
      wr_reg     <= wr_next;
      mrd_reg    <= mrd_next;
      ack_reg    <= ack_next;
      xen_reg    <= xen_next;
      xdir_reg   <= xdir_next;
      irqs_reg   <= irqs_next;
      sers_reg   <= sers_next;
      paddr_reg  <= paddr_next;
      pout_reg   <= pout_next;
      oe_n_reg   <= oe_n_next;
      rdata_reg  <= rdata_next;
      ready_reg  <= ready_next;
      na_reg     <= na_next;
    end
  end

  assign IO_RD_CMD          = rd_reg;
  assign IO_WR_CMD          = wr_reg;
  assign MEM_RD_CMD         = mrd_reg;
  assign IRQ_ACK_STROBE     = ack_reg;
  assign XCVR_ENABLE        = xen_reg;
  assign XCVR_DIR           = xdir_reg;
  assign IRQ_CTRL_SELECT    = irqs_reg;
  assign SERIAL_CTRL_SELECT = sers_reg;
  assign PERIPH_ADDR        = paddr_reg;
  assign PDATA_OUT          = pout_reg;
  assign PDATA_OE_N         = oe_n_reg;
  assign bus.rdata          = rdata_reg;
  assign bus.ready          = ready_reg;
  assign bus.next_addr_req  = na_reg;
endmodule

// file: hdl/cpu_bus_master.sv
`timescale 1ns/10ps
module cpu_bus_master (
  // clock and reset
  input  wire logic                          SYS_CLK,
  input  wire logic                          RST,
  // local bus toward the controller
  local_bus_if.cpu                           bus,
  // user request
  input  wire logic                          REQ,
  input  wire logic                          REQ_IO,
  input  wire logic                          REQ_WRITE,
  input  wire logic [io_bus_pkg::ADDR_W-1:0] REQ_ADDR,
  input  wire logic [io_bus_pkg::DATA_W-1:0] REQ_WDATA,
  // user answer
  output logic                               BUSY,
  output logic                               DONE,
  output logic [io_bus_pkg::DATA_W-1:0]      RDATA,
  // interrupt
  input  wire logic                          CPU_IRQ_IN,
  output logic                               ACK_DONE,
  output logic [io_bus_pkg::DATA_W-1:0]      ACK_VECTOR
);
  import io_bus_pkg::*;

  host_state_t       state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic              ads_reg, ads_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              w_r_reg, w_r_next;
  logic              m_io_reg, m_io_next;
  logic              d_c_reg, d_c_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic              is_ack_reg, is_ack_next;
  logic              second_reg, second_next;
  logic              busy_reg, busy_next;
  logic              done_reg, done_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              ackd_reg, ackd_next;
  logic [DATA_W-1:0] vec_reg, vec_next;

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    ads_next    = 1'b0;
    addr_next   = addr_reg;
    w_r_next    = w_r_reg;
    m_io_next   = m_io_reg;
    d_c_next    = d_c_reg;
    wdata_next  = wdata_reg;
    is_ack_next = is_ack_reg;
    second_next = second_reg;
    done_next   = 1'b0;
    rdata_next  = rdata_reg;
    ackd_next   = 1'b0;
    vec_next    = vec_reg;
    case (state_reg)
      H_IDLE: begin
        // user request outranks a pending interrupt
        if (REQ) begin
          state_next  = H_ADS;
          ads_next    = 1'b1;
          addr_next   = REQ_ADDR;
          m_io_next   = !REQ_IO;
          d_c_next    = 1'b1;
          w_r_next    = REQ_WRITE;
          wdata_next  = REQ_WDATA;
          is_ack_next = 1'b0;
        end else if (CPU_IRQ_IN) begin
          state_next  = H_ADS;
          ads_next    = 1'b1;
          addr_next   = ACK1_ADDR;
          m_io_next   = 1'b0;
          d_c_next    = 1'b0;
          w_r_next    = 1'b0;
          is_ack_next = 1'b1;
          second_next = 1'b0;
        end
      end
      H_ADS: begin
        state_next = H_WAIT;
      end
      H_WAIT: begin
        if (bus.ready) begin
          if (is_ack_reg && !second_reg) begin
            state_next = H_GAP;
            cnt_next   = ACK_GAP_CYC - CNT_ONE;
          end else if (is_ack_reg) begin
            state_next = H_IDLE;
            vec_next   = bus.rdata;
            ackd_next  = 1'b1;
          end else begin
            state_next = H_IDLE;
            rdata_next = w_r_reg ? rdata_reg : bus.rdata;
            done_next  = 1'b1;
          end
        end
      end
      H_GAP: begin
        if (cnt_reg != CNT_ZERO) begin
          cnt_next = cnt_reg - CNT_ONE;
        end else begin
          state_next  = H_ADS;
          ads_next    = 1'b1;
          addr_next   = ACK2_ADDR;
          second_next = 1'b1;
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
    busy_next = (state_next != H_IDLE);
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_reg  <= H_IDLE;
      cnt_reg    <= CNT_ZERO;
      ads_reg    <= 1'b0;
      addr_reg   <= ADDR_RESET;
      w_r_reg    <= 1'b0;
      m_io_reg   <= 1'b0;
      d_c_reg    <= 1'b0;
      wdata_reg  <= DATA_RESET;
      is_ack_reg <= 1'b0;
      second_reg <= 1'b0;
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      rdata_reg  <= DATA_RESET;
      ackd_reg   <= 1'b0;
      vec_reg    <= DATA_RESET;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      ads_reg    <= ads_next;
      addr_reg   <= addr_next;
      w_r_reg    <= w_r_next;
      m_io_reg   <= m_io_next;
      d_c_reg    <= d_c_next;
      wdata_reg  <= wdata_next;
      is_ack_reg <= is_ack_next;
      second_reg <= second_next;
      busy_reg   <= busy_next;
      done_reg   <= done_next;
      rdata_reg  <= rdata_next;
      ackd_reg   <= ackd_next;
      vec_reg    <= vec_next;
    end
  end

  assign bus.ads   = ads_reg;
  assign bus.addr  = addr_reg;
  assign bus.w_r   = w_r_reg;
  assign bus.m_io  = m_io_reg;
  assign bus.d_c   = d_c_reg;
  assign bus.wdata = wdata_reg;
  assign BUSY       = busy_reg;
  assign DONE       = done_reg;
  assign RDATA      = rdata_reg;
  assign ACK_DONE   = ackd_reg;
  assign ACK_VECTOR = vec_reg;
endmodule

// file: tb/io_bus_chk.sv
`timescale 1ns/10ps
module io_bus_chk (
  // clock and reset
  input wire logic                          SYS_CLK,
  input wire logic                          RST,
  // local bus
  input wire logic                          ads,
  input wire logic [io_bus_pkg::ADDR_W-1:0] addr,
  input wire logic                          w_r,
  input wire logic                          m_io,
  input wire logic                          d_c,
  input wire logic                          ready,
  input wire logic                          next_addr_req,
  // controller outputs
  input wire logic                          IO_RD_CMD,
  input wire logic                          IO_WR_CMD,
  input wire logic                          MEM_RD_CMD,
  input wire logic                          IRQ_ACK_STROBE,
  input wire logic                          XCVR_ENABLE,
  input wire logic                          XCVR_DIR,
  input wire logic                          IRQ_CTRL_SELECT,
  input wire logic                          SERIAL_CTRL_SELECT,
  input wire logic [1:0]                    PERIPH_ADDR,
  input wire logic                          PDATA_OE_N
);
  import io_bus_pkg::*;
  logic       sel;
  logic [4:0] rd_len_reg, rd_len_next, wr_len_reg, wr_len_next;
  logic [3:0] sel_len_reg, sel_len_next, gap_reg, gap_next;

  // widths above eight cycles are counted, not repeated
  always_comb begin
    sel = IRQ_CTRL_SELECT | SERIAL_CTRL_SELECT;
    rd_len_next = IO_RD_CMD ? rd_len_reg + 5'h01 : 5'h00;
    wr_len_next = IO_WR_CMD ? wr_len_reg + 5'h01 : 5'h00;
    sel_len_next = !sel ? 4'h0 : (sel_len_reg == 4'hF ? 4'hF : sel_len_reg + 4'h1);
    gap_next = (IO_RD_CMD | IO_WR_CMD | IRQ_ACK_STROBE) ? 4'h0 : (gap_reg == 4'hF ? 4'hF : gap_reg + 4'h1);
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rd_len_reg <= 5'h00;
      wr_len_reg <= 5'h00;
      sel_len_reg <= 4'h0;
      gap_reg <= 4'hF;
    end else begin
      rd_len_reg <= rd_len_next;
      wr_len_reg <= wr_len_next;
      sel_len_reg <= sel_len_next;
      gap_reg <= gap_next;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence rd_hold_s;
    sel [*6];
  endsequence
  sequence wr_hold_s;
    sel [*7];
  endsequence

  AST_RD_WIDTH: assert property ($fell(IO_RD_CMD) |-> rd_len_reg == {1'b0, RD_CMD_CYC})
    else $error("read command width wrong");
  AST_WR_WIDTH: assert property ($fell(IO_WR_CMD) |-> wr_len_reg == {1'b0, WR_CMD_CYC})
    else $error("write command width wrong");
  AST_ADDR_SETUP: assert property (($rose(IO_RD_CMD) || $rose(IO_WR_CMD)) |-> sel_len_reg >= ADDR_SETUP_CYC)
    else $error("address setup too short");
  AST_RD_HOLD: assert property ($fell(IO_RD_CMD) |-> rd_hold_s)
    else $error("address hold after read too short");
  AST_WR_HOLD: assert property ($fell(IO_WR_CMD) |-> wr_hold_s)
    else $error("address hold after write too short");
  AST_RECOVERY: assert property (($rose(IO_RD_CMD) || $rose(IO_WR_CMD) || $rose(IRQ_ACK_STROBE)) |-> gap_reg >= RECOVERY_CYC)
    else $error("command recovery too short");
  AST_ACK_WAIT: assert property (ads && !m_io && !d_c && !w_r |-> ##1 !ready [*2])
    else $error("acknowledge cycle without wait");
  AST_ACK_ONLY: assert property (IRQ_ACK_STROBE |-> !IO_RD_CMD && !IO_WR_CMD && !MEM_RD_CMD)
    else $error("command during acknowledge");
  AST_WR_DATA: assert property (IO_WR_CMD |-> XCVR_DIR && !PDATA_OE_N)
    else $error("write data not driven");
  AST_RD_DIR: assert property (IO_RD_CMD |-> !XCVR_DIR && PDATA_OE_N)
    else $error("read direction wrong");
  AST_XCVR_ON: assert property ((IO_RD_CMD || IO_WR_CMD || IRQ_ACK_STROBE) |-> XCVR_ENABLE)
    else $error("transceiver off during command");
  AST_WR_DHOLD: assert property ($fell(IO_WR_CMD) |-> XCVR_ENABLE && !PDATA_OE_N)
    else $error("write data dropped with command");
  AST_ZW_NEXT: assert property (ads && m_io && addr[15:14] == MEM_SEL_ZW |-> ##[1:2] next_addr_req ##[0:2] ready)
    else $error("zero wait cycle slow");
  AST_ONE_WAIT: assert property (ads && m_io && addr[15:14] != MEM_SEL_ZW |-> ##1 !next_addr_req ##[1:3] ready)
    else $error("one wait cycle wrong");
  AST_PADDR: assert property (ads && !m_io |-> ##1 PERIPH_ADDR == $past(addr[3:2]))
    else $error("peripheral address wrong");
  AST_SEL: assert property (ads && !m_io && d_c |-> ##1 SERIAL_CTRL_SELECT == (addr[5:4] == IO_SEL_SERIAL))
    else $error("serial select wrong");
endmodule

// file: tb/tb_io_bus_command_timing.sv
`timescale 1ns/10ps
module tb_io_bus_command_timing;
  import io_bus_pkg::*;
  logic              SYS_CLK, RST, req, req_io, req_write, cpu_irq_in;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, periph_val, pdata_in, pdata_out, rdata, ack_vector;
  logic              io_rd_cmd, io_wr_cmd, mem_rd_cmd, irq_ack_strobe, xcvr_enable, xcvr_dir;
  logic              irq_sel, serial_sel, pdata_oe_n, busy, done, ack_done;
  logic [1:0]        periph_addr;
  int                fail_count, checked, lat, wr_lat, rd_lat, zw_lat, ack_seen, mem_seen, na_seen;

  local_bus_if bus_if ();
  io_cmd_ctrl io_cmd_ctrl_inst (.SYS_CLK(SYS_CLK), .RST(RST), .bus(bus_if), .IO_RD_CMD(io_rd_cmd),
    .IO_WR_CMD(io_wr_cmd), .MEM_RD_CMD(mem_rd_cmd), .IRQ_ACK_STROBE(irq_ack_strobe), .XCVR_ENABLE(xcvr_enable),
    .XCVR_DIR(xcvr_dir), .IRQ_CTRL_SELECT(irq_sel), .SERIAL_CTRL_SELECT(serial_sel), .PERIPH_ADDR(periph_addr),
    .PDATA_IN(pdata_in), .PDATA_OUT(pdata_out), .PDATA_OE_N(pdata_oe_n));
  cpu_bus_master cpu_bus_master_inst (.SYS_CLK(SYS_CLK), .RST(RST), .bus(bus_if), .REQ(req), .REQ_IO(req_io),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .BUSY(busy), .DONE(done), .RDATA(rdata),
    .CPU_IRQ_IN(cpu_irq_in), .ACK_DONE(ack_done), .ACK_VECTOR(ack_vector));
  io_bus_chk io_bus_chk_inst (.SYS_CLK(SYS_CLK), .RST(RST), .ads(bus_if.ads), .addr(bus_if.addr), .w_r(bus_if.w_r),
    .m_io(bus_if.m_io), .d_c(bus_if.d_c), .ready(bus_if.ready), .next_addr_req(bus_if.next_addr_req),
    .IO_RD_CMD(io_rd_cmd), .IO_WR_CMD(io_wr_cmd), .MEM_RD_CMD(mem_rd_cmd), .IRQ_ACK_STROBE(irq_ack_strobe),
    .XCVR_DIR(xcvr_dir), .IRQ_CTRL_SELECT(irq_sel), .SERIAL_CTRL_SELECT(serial_sel), .PERIPH_ADDR(periph_addr),
    .XCVR_ENABLE(xcvr_enable), .PDATA_OE_N(pdata_oe_n));

  // peripheral drives its byte only under a read command or acknowledge strobe; inverse otherwise
  assign pdata_in = (io_rd_cmd | irq_ack_strobe) ? periph_val : ~periph_val;
  always @(posedge irq_ack_strobe) ack_seen++;
  always @(posedge mem_rd_cmd) mem_seen++;
  always @(posedge bus_if.next_addr_req) na_seen++;

  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task automatic wrap_up();
    $display("errors %0d checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (exp !== got) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic start(input logic io, input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    #1;
    req = 1'b1;
    req_io = io;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(posedge SYS_CLK);
    #1;
    req = 1'b0;
  endtask

  task automatic access(input logic io, input logic wr, input logic [15:0] a, input logic [7:0] d);
    int i;
    start(io, wr, a, d);
    lat = 0;
    for (i = 0; i < 200 && done !== 1'b1; i++) begin
      @(posedge SYS_CLK);
      #1;
      lat++;
    end
    if (i == 200) begin
      fail_count++;
      $display("mismatch done expected 1 seen 0");
      wrap_up();
    end
  endtask

  task automatic idle_chk(input string name);
    chk(name, 16'h0001, 16'({io_rd_cmd, io_wr_cmd, mem_rd_cmd, irq_ack_strobe, xcvr_enable, busy, pdata_oe_n}));
  endtask

  initial begin
    int k;
    RST = 1'b1;
    req = 1'b0;
    req_io = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 8'h00;
    cpu_irq_in = 1'b0;
    periph_val = 8'h00;
    repeat (6) @(posedge SYS_CLK);
    #1;
    RST = 1'b0;
    idle_chk("after reset");
    for (k = 0; k < 4; k++) begin
      access(1'b1, 1'b1, 16'h0010 + 16'(k * 4), 8'hA0 + 8'(k));
      chk("serial addr", 16'(k), 16'(periph_addr));
      chk("write data", 16'hA0 + 16'(k), 16'(pdata_out));
    end
    wr_lat = lat;
    repeat (20) @(posedge SYS_CLK);
    #1;
    periph_val = 8'h5C;
    access(1'b1, 1'b0, 16'h0004, 8'h00);
    rd_lat = lat;
    chk("irq read", 16'h005C, 16'(rdata));
    chk("reg select", 16'h0001, 16'(periph_addr[0]));
    chk("write minus read", 16'h0002, 16'(wr_lat - rd_lat));
    periph_val = 8'hC3;
    access(1'b1, 1'b0, 16'h0000, 8'h00);
    chk("back read", 16'h00C3, 16'(rdata));
    chk("reg select", 16'h0000, 16'(periph_addr[0]));
    access(1'b0, 1'b0, 16'h0000, 8'h00);
    zw_lat = lat;
    access(1'b0, 1'b0, 16'h4000, 8'h00);
    chk("one wait extra", 16'h0001, 16'(lat - zw_lat));
    chk("mem commands", 16'h0002, 16'(mem_seen));
    access(1'b0, 1'b1, 16'h4000, 8'h00);
    chk("mem write cmds", 16'h0002, 16'(mem_seen));
    chk("mem write wait", 16'h0001, 16'(lat - zw_lat));
    chk("next addr", 16'h0001, 16'(na_seen));
    chk("io slower", 16'h0001, 16'(rd_lat > zw_lat));
    periph_val = 8'h3B;
    cpu_irq_in = 1'b1;
    for (k = 0; k < 400 && ack_done !== 1'b1; k++) begin
      @(posedge SYS_CLK);
      #1;
      if (ack_seen > 0)
        cpu_irq_in = 1'b0;
    end
    if (k == 400) begin
      fail_count++;
      $display("mismatch ack_done expected 1 seen 0");
      wrap_up();
    end
    chk("vector", 16'h003B, 16'(ack_vector));
    chk("ack count", 16'h0002, 16'(ack_seen));
    start(1'b1, 1'b1, 16'h0010, 8'h77);
    repeat (10) @(posedge SYS_CLK);
    #1;
    RST = 1'b1;
    #2;
    idle_chk("mid reset");
    @(posedge SYS_CLK);
    #1;
    RST = 1'b0;
    periph_val = 8'h96;
    access(1'b1, 1'b0, 16'h0014, 8'h00);
    chk("read after reset", 16'h0096, 16'(rdata));
    wrap_up();
  end
endmodule
